// ---- src/lsd_pkg.sv ----
// constants, types and level decoding shared by the segment driver files
package lsd_pkg;

   localparam int HALF_W      = 20;
   localparam int NUM_HALVES  = 2;
   localparam int SEG_W       = HALF_W * NUM_HALVES;
   localparam int SYNC_STAGES = 2;

   // clock rates in kHz
   localparam int CLK_SYS_KHZ       = 100000;
   localparam int SHIFT_CLK_MAX_KHZ = 3300;
   // least shift clock period in system cycles, rounded up
   localparam int SHIFT_MIN_CYC     = (CLK_SYS_KHZ + SHIFT_CLK_MAX_KHZ - 1) / SHIFT_CLK_MAX_KHZ;

   // values after reset of the control flops
   localparam logic [SYNC_STAGES-1:0] SYNC_RST_VAL = 2'h0;
   localparam logic                   EDGE_RST_VAL = 1'h0;

   typedef enum logic [1:0] {
      LVL_VDD,
      LVL_V2,
      LVL_V3,
      LVL_V5
   } lsd_level_e;

   typedef logic [SEG_W-1:0][1:0] lsd_seg_vec_t;

   // drive level of one segment from its latched bit and the alternation level
   function automatic lsd_level_e lsd_level(input logic bit_val, input logic alt);
      if (bit_val) begin
         return alt ? LVL_V5 : LVL_VDD;
      end
      return alt ? LVL_V3 : LVL_V2;
   endfunction

   function automatic lsd_seg_vec_t lsd_seg_vec(input logic [SEG_W-1:0] lat, input logic alt);
      lsd_seg_vec_t v;
      v = '0;
      for (int i = 0; i < SEG_W; i++) begin
         v[i] = lsd_level(lat[i], alt);
      end
      return v;
   endfunction

endpackage

// ---- src/lsd_half_if.sv ----
// link between the top and one 20-bit shift half
`timescale 1ns/1ps
interface lsd_half_if;
   import lsd_pkg::*;
   logic              shift_en;
   logic              dir;
   logic              ser_in;
   logic [HALF_W-1:0] bits;

   modport ctl  (output shift_en, output dir, output ser_in, input bits);
   modport half (input shift_en, input dir, input ser_in, output bits);
endinterface

// ---- src/lsd_shift_half.sv ----
// one 20-bit bidirectional shift register half, no reset
`timescale 1ns/1ps
module lsd_shift_half
   import lsd_pkg::*;
(
   input wire logic clk,
   lsd_half_if.half hif
);

   typedef struct packed {
      logic [HALF_W-1:0] bits;
   } lsd_half_s;

   lsd_half_s st_ff;
   lsd_half_s nxt_st;

   // index 0 is the first bit of the half
   always_comb begin
      nxt_st = st_ff;
      if (hif.shift_en) begin
         if (hif.dir) begin
            nxt_st.bits = {st_ff.bits[HALF_W-2:0], hif.ser_in};
         end else begin
            nxt_st.bits = {hif.ser_in, st_ff.bits[HALF_W-1:1]};
         end
      end
   end

   // contents undefined until loaded, so no reset
   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   assign hif.bits = st_ff.bits;

   a_shift_up_entry: assert property (@(posedge clk)
      hif.shift_en && hif.dir |=> hif.bits[0] == $past(hif.ser_in)
                                  && hif.bits[HALF_W-1:1] === $past(hif.bits[HALF_W-2:0]))
      else $error("upward shift lost or misplaced a bit");

   a_shift_down_entry: assert property (@(posedge clk)
      hif.shift_en && !hif.dir |=> hif.bits[HALF_W-1] == $past(hif.ser_in)
                                   && hif.bits[HALF_W-2:0] === $past(hif.bits[HALF_W-1:1]))
      else $error("downward shift lost or misplaced a bit");

   a_shift_idle_hold: assert property (@(posedge clk)
      !hif.shift_en |=> $stable(hif.bits))
      else $error("shift register moved without a shift clock edge");

endmodule

// ---- src/lsd_segment_driver.sv ----
// serial-in 40-output segment driver: shift halves, level latch, level select
`timescale 1ns/1ps
module lsd_segment_driver
   import lsd_pkg::*;
(
   input  wire logic                 CLK_SYS,
   input  wire logic                 SRST,
   input  wire logic                 SHIFT_CLK,
   input  wire logic                 LATCH_PULSE,
   input  wire logic                 ALTERNATION_IN,
   input  wire logic                 LOW_HALF_DIR_SELECT,
   input  wire logic                 HIGH_HALF_DIR_SELECT,
   input  wire logic                 LOW_HALF_CASCADE_A_I,
   output logic                      LOW_HALF_CASCADE_A_O,
   output logic                      LOW_HALF_CASCADE_A_OE,
   input  wire logic                 LOW_HALF_CASCADE_B_I,
   output logic                      LOW_HALF_CASCADE_B_O,
   output logic                      LOW_HALF_CASCADE_B_OE,
   input  wire logic                 HIGH_HALF_CASCADE_A_I,
   output logic                      HIGH_HALF_CASCADE_A_O,
   output logic                      HIGH_HALF_CASCADE_A_OE,
   input  wire logic                 HIGH_HALF_CASCADE_B_I,
   output logic                      HIGH_HALF_CASCADE_B_O,
   output logic                      HIGH_HALF_CASCADE_B_OE,
   output lsd_pkg::lsd_seg_vec_t     SEGMENT_OUTPUTS
);

   typedef struct packed {
      logic [SYNC_STAGES-1:0]                  scl_s;
      logic                                    scl_prev;
      logic [SYNC_STAGES-1:0]                  lp_s;
      logic [SYNC_STAGES-1:0]                  alt_s;
      logic [NUM_HALVES-1:0][SYNC_STAGES-1:0]  dir_s;
      logic [NUM_HALVES-1:0][SYNC_STAGES-1:0]  ca_s;
      logic [NUM_HALVES-1:0][SYNC_STAGES-1:0]  cb_s;
      logic [NUM_HALVES-1:0]                   ca_o;
      logic [NUM_HALVES-1:0]                   ca_oe;
      logic [NUM_HALVES-1:0]                   cb_o;
      logic [NUM_HALVES-1:0]                   cb_oe;
      logic [SEG_W-1:0]                        latch;
      lsd_seg_vec_t                            seg;
   } lsd_top_s;

   lsd_top_s              st_ff;
   lsd_top_s              nxt_st;
   logic                  shift_fall;
   logic [SEG_W-1:0]      shift_bits;
   logic [NUM_HALVES-1:0] pin_a;
   logic [NUM_HALVES-1:0] pin_b;

   lsd_half_if hif [NUM_HALVES] ();

   assign pin_a = {HIGH_HALF_CASCADE_A_I, LOW_HALF_CASCADE_A_I};
   assign pin_b = {HIGH_HALF_CASCADE_B_I, LOW_HALF_CASCADE_B_I};

   // falling edge seen on the second sync stage
   assign shift_fall = st_ff.scl_prev & ~st_ff.scl_s[1];

   genvar h;
   generate
      for (h = 0; h < NUM_HALVES; h++) begin : g_half
         // each half steered by its own select
         assign hif[h].shift_en = shift_fall;
         assign hif[h].dir      = st_ff.dir_s[h][1];
         // serial input pin follows the direction
         assign hif[h].ser_in   = st_ff.dir_s[h][1] ? st_ff.ca_s[h][1]
                                                    : st_ff.cb_s[h][1];
         assign shift_bits[h*HALF_W +: HALF_W] = hif[h].bits;

         lsd_shift_half u_half (
            .clk (CLK_SYS),
            .hif (hif[h])
         );
      end
   endgenerate

   always_comb begin
      nxt_st          = st_ff;
      // two-stage synchronisers for every pin input except SRST
      nxt_st.scl_s    = {st_ff.scl_s[0], SHIFT_CLK};
      nxt_st.lp_s     = {st_ff.lp_s[0], LATCH_PULSE};
      nxt_st.alt_s    = {st_ff.alt_s[0], ALTERNATION_IN};
      nxt_st.scl_prev = st_ff.scl_s[1];
      for (int i = 0; i < NUM_HALVES; i++) begin
         nxt_st.dir_s[i] = {st_ff.dir_s[i][0],
                            (i == 0) ? LOW_HALF_DIR_SELECT : HIGH_HALF_DIR_SELECT};
         nxt_st.ca_s[i]  = {st_ff.ca_s[i][0], pin_a[i]};
         nxt_st.cb_s[i]  = {st_ff.cb_s[i][0], pin_b[i]};
         // output pin is b when shifting up, a when shifting down
         nxt_st.cb_oe[i] = st_ff.dir_s[i][1];
         nxt_st.ca_oe[i] = ~st_ff.dir_s[i][1];
         nxt_st.cb_o[i]  = hif_last(i, 1'b1);
         nxt_st.ca_o[i]  = hif_last(i, 1'b0);
      end
      // latch transparent while pulse high
      if (st_ff.lp_s[1]) begin
         nxt_st.latch = shift_bits;
      end
      nxt_st.seg = lsd_seg_vec(st_ff.latch, st_ff.alt_s[1]);
      if (SRST) begin
         // latch left out of reset on purpose
         nxt_st.scl_s    = SYNC_RST_VAL;
         nxt_st.scl_prev = EDGE_RST_VAL;
         nxt_st.lp_s     = SYNC_RST_VAL;
      end
   end

   // last bit of a half in the given direction
   function automatic logic hif_last(input int idx, input logic up);
      logic [HALF_W-1:0] b;
      b = shift_bits[idx*HALF_W +: HALF_W];
      return up ? b[HALF_W-1] : b[0];
   endfunction

   always_ff @(posedge CLK_SYS) begin
      st_ff <= nxt_st;
   end

   assign LOW_HALF_CASCADE_A_O   = st_ff.ca_o[0];
   assign LOW_HALF_CASCADE_A_OE  = st_ff.ca_oe[0];
   assign LOW_HALF_CASCADE_B_O   = st_ff.cb_o[0];
   assign LOW_HALF_CASCADE_B_OE  = st_ff.cb_oe[0];
   assign HIGH_HALF_CASCADE_A_O  = st_ff.ca_o[1];
   assign HIGH_HALF_CASCADE_A_OE = st_ff.ca_oe[1];
   assign HIGH_HALF_CASCADE_B_O  = st_ff.cb_o[1];
   assign HIGH_HALF_CASCADE_B_OE = st_ff.cb_oe[1];
   assign SEGMENT_OUTPUTS        = st_ff.seg;

   // bounds of the shift edge spacing cover
   localparam int SHIFT_GAP_LO = SHIFT_MIN_CYC;
   localparam int SHIFT_GAP_HI = SHIFT_MIN_CYC + 5;

   default clocking cb_sys @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   a_low_up_entry: assert property (
      shift_fall && st_ff.dir_s[0][1] |=> shift_bits[0] == $past(st_ff.ca_s[0][1]))
      else $error("low half upward entry not from pin a");

   a_high_down_entry: assert property (
      shift_fall && !st_ff.dir_s[1][1] |=> shift_bits[SEG_W-1] == $past(st_ff.cb_s[1][1]))
      else $error("high half downward entry not from pin b");

   a_halves_apart: assert property (
      shift_fall && st_ff.dir_s[0][1] && !st_ff.dir_s[1][1]
      |=> shift_bits[HALF_W-1] === $past(shift_bits[HALF_W-2])
          && shift_bits[HALF_W] === $past(shift_bits[HALF_W+1]))
      else $error("bits crossed between halves");

   a_latch_write: assert property (
      st_ff.lp_s[1] |=> st_ff.latch == $past(shift_bits))
      else $error("latch did not take the shift bits");

   a_latch_hold: assert property (
      !st_ff.lp_s[1] |=> $stable(st_ff.latch))
      else $error("latch changed while pulse low");

   a_seg_level_map: assert property (
      ##1 SEGMENT_OUTPUTS == lsd_seg_vec($past(st_ff.latch), $past(st_ff.alt_s[1])))
      else $error("segment level wrong for bit and alternation");

   a_low_pin_roles: assert property (
      $stable(st_ff.dir_s[0][1]) |=> LOW_HALF_CASCADE_B_OE == $past(st_ff.dir_s[0][1])
                                    && LOW_HALF_CASCADE_A_OE != LOW_HALF_CASCADE_B_OE)
      else $error("low cascade pin roles wrong");

   a_high_pin_roles: assert property (
      $stable(st_ff.dir_s[1][1]) |=> HIGH_HALF_CASCADE_B_OE == $past(st_ff.dir_s[1][1])
                                    && HIGH_HALF_CASCADE_A_OE != HIGH_HALF_CASCADE_B_OE)
      else $error("high cascade pin roles wrong");

   a_cascade_out: assert property (
      shift_fall && st_ff.dir_s[0][1] ##1 st_ff.dir_s[0][1]
      |=> LOW_HALF_CASCADE_B_O === $past(shift_bits[HALF_W-1]))
      else $error("low cascade output not last bit");

   a_low_down_entry: assert property (
      shift_fall && !st_ff.dir_s[0][1] |=> shift_bits[HALF_W-1] == $past(st_ff.cb_s[0][1]))
      else $error("low half downward entry not from pin b");

   a_high_up_entry: assert property (
      shift_fall && st_ff.dir_s[1][1] |=> shift_bits[HALF_W] == $past(st_ff.ca_s[1][1]))
      else $error("high half upward entry not from pin a");

   a_low_cascade_down: assert property (
      shift_fall && !st_ff.dir_s[0][1] ##1 !st_ff.dir_s[0][1]
      |=> LOW_HALF_CASCADE_A_O === $past(shift_bits[0]))
      else $error("low cascade a output not first bit");

   a_high_cascade_out: assert property (
      shift_fall && !st_ff.dir_s[1][1] ##1 !st_ff.dir_s[1][1]
      |=> HIGH_HALF_CASCADE_A_O === $past(shift_bits[HALF_W]))
      else $error("high cascade a output not first bit");

   a_high_cascade_up: assert property (
      shift_fall && st_ff.dir_s[1][1] ##1 st_ff.dir_s[1][1]
      |=> HIGH_HALF_CASCADE_B_O === $past(shift_bits[SEG_W-1]))
      else $error("high cascade b output not last bit");

   c_shift_edge: cover property (shift_fall ##[SHIFT_GAP_LO:SHIFT_GAP_HI] shift_fall);
   c_chained_up: cover property (shift_fall && st_ff.dir_s[0][1] && st_ff.dir_s[1][1]);
   c_latch_pulse: cover property (st_ff.lp_s[1] ##1 !st_ff.lp_s[1]);
   c_opposite_dirs: cover property (shift_fall && st_ff.dir_s[0][1] && !st_ff.dir_s[1][1]);
   c_alt_flip: cover property (st_ff.alt_s[1] ##1 !st_ff.alt_s[1]);

endmodule

// ---- tb/lsd_ctl_model.sv ----
// controller model: streams display bits, pulses the latch, drives alternation
`timescale 1ns/1ps
module lsd_ctl_model (
   input  wire logic clk,
   output logic      shift_clk,
   output logic      lo_d,
   output logic      hi_d,
   output logic      latch_pulse,
   output logic      alt
);
   initial begin
      {shift_clk, lo_d, hi_d, latch_pulse, alt} = '0;
   end
   task automatic send(input logic [39:0] lo, input logic [39:0] hi);
      for (int k = 0; k < 40; k++) begin
         @(posedge clk) {lo_d, hi_d} <= {lo[k], hi[k]};
         repeat (4) @(posedge clk);
         shift_clk <= 1'h1;
         repeat (12) @(posedge clk);
         shift_clk <= 1'h0;
         repeat (14) @(posedge clk);
      end
      {lo_d, hi_d} <= ~{lo_d, hi_d};
   endtask
   task automatic latch();
      @(posedge clk) latch_pulse <= 1'h1;
      repeat (4) @(posedge clk);
      latch_pulse <= 1'h0;
      repeat (6) @(posedge clk);
   endtask
   task automatic set_alt(input logic a);
      @(posedge clk) alt <= a;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ---- tb/test_lsd_segment_driver.sv ----
// self-checking bench for the segment driver against the controller model
`timescale 1ns/1ps
module test_lsd_segment_driver;
   import lsd_pkg::*;
   typedef struct packed {
      logic        lsel;
      logic        hsel;
      logic        alt;
      logic        chain;
      logic [39:0] lo;
      logic [39:0] hi;
   } lsd_row_s;
   lsd_row_s rows [5] = '{
      '{1'h1, 1'h1, 1'h0, 1'h0, 40'hA5F03C9617, 40'h5A0FC369E8},
      '{1'h0, 1'h0, 1'h1, 1'h0, 40'h0123456789, 40'hFEDCBA9876},
      '{1'h1, 1'h0, 1'h1, 1'h0, 40'h96C3E1F00F, 40'h3C5A96E187},
      '{1'h0, 1'h1, 1'h0, 1'h0, 40'h7E81C33C18, 40'hB4D22D4BE1},
      '{1'h1, 1'h1, 1'h1, 1'h1, 40'hC0FFEE1234, 40'h0000000000}};
   logic         clk;
   logic         srst  = 1'h1;
   logic         lsel  = 1'h1;
   logic         hsel  = 1'h1;
   logic         chain = 1'h0;
   logic         sck, lo_d, hi_d, lp, alt;
   logic         la_o, la_oe, lb_o, lb_oe, ha_o, ha_oe, hb_o, hb_oe;
   lsd_seg_vec_t seg;
   logic [39:0]  e, old;
   lsd_row_s     h;
   int           n_fail = 0;
   int           compares = 0;
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   lsd_ctl_model ctl_inst (.clk(clk), .shift_clk(sck), .lo_d(lo_d), .hi_d(hi_d),
      .latch_pulse(lp), .alt(alt));
   lsd_segment_driver lsd_segment_driver_inst (.CLK_SYS(clk), .SRST(srst), .SHIFT_CLK(sck),
      .LATCH_PULSE(lp), .ALTERNATION_IN(alt), .LOW_HALF_DIR_SELECT(lsel),
      .HIGH_HALF_DIR_SELECT(hsel), .LOW_HALF_CASCADE_A_I(la_oe ? la_o : lo_d),
      .LOW_HALF_CASCADE_A_O(la_o), .LOW_HALF_CASCADE_A_OE(la_oe),
      .LOW_HALF_CASCADE_B_I(lb_oe ? lb_o : lo_d), .LOW_HALF_CASCADE_B_O(lb_o),
      .LOW_HALF_CASCADE_B_OE(lb_oe), .HIGH_HALF_CASCADE_A_I(chain ? lb_o : (ha_oe ? ha_o : hi_d)),
      .HIGH_HALF_CASCADE_A_O(ha_o), .HIGH_HALF_CASCADE_A_OE(ha_oe),
      .HIGH_HALF_CASCADE_B_I(hb_oe ? hb_o : hi_d), .HIGH_HALF_CASCADE_B_O(hb_o),
      .HIGH_HALF_CASCADE_B_OE(hb_oe), .SEGMENT_OUTPUTS(seg));
   task automatic report_and_stop();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic want);
      compares++;
      if (got !== want) begin
         n_fail++;
         $display("unexpected pin at %0t: got %b want %b", $time, got, want);
      end
   endtask
   task automatic cmp_seg(input lsd_seg_vec_t want);
      compares++;
      if (seg !== want) begin
         n_fail++;
         $display("unexpected segments at %0t: got %h want %h", $time, seg, want);
      end
   endtask
   function automatic lsd_seg_vec_t exp_seg(input logic [39:0] b, input logic a);
      lsd_seg_vec_t v;
      for (int i = 0; i < 40; i++) begin
         v[i] = b[i] ? (a ? LVL_V5 : LVL_VDD) : (a ? LVL_V3 : LVL_V2);
      end
      return v;
   endfunction
   task automatic model(input lsd_row_s r);
      logic b;
      for (int k = 0; k < 40; k++) begin
         b = r.chain ? e[19] : r.hi[k];
         e[19:0] = r.lsel ? {e[18:0], r.lo[k]} : {r.lo[k], e[19:1]};
         e[39:20] = r.hsel ? {e[38:20], b} : {b, e[39:21]};
      end
   endtask
   task automatic check_oe(input lsd_row_s r);
      cmp_bit(la_oe, ~r.lsel);
      cmp_bit(lb_oe, r.lsel);
      cmp_bit(ha_oe, ~r.hsel);
      cmp_bit(hb_oe, r.hsel);
   endtask
   task automatic check_out(input lsd_row_s r);
      cmp_bit(r.lsel ? lb_o : la_o, r.lsel ? e[19] : e[0]);
      cmp_bit(r.hsel ? hb_o : ha_o, r.hsel ? e[39] : e[20]);
   endtask
   task automatic run_row(input lsd_row_s r);
      @(posedge clk) {lsel, hsel, chain} <= {r.lsel, r.hsel, r.chain};
      ctl_inst.set_alt(r.alt);
      check_oe(r);
      ctl_inst.send(r.lo, r.hi);
      model(r);
      check_out(r);
      ctl_inst.latch();
      cmp_seg(exp_seg(e, r.alt));
   endtask
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      repeat (4) @(posedge clk);
      check_oe(rows[0]);
      foreach (rows[i]) run_row(rows[i]);
      h = rows[4];
      h.lo = ~h.lo;
      h.hi = 40'hFFFFF0000F;
      old = e;
      ctl_inst.send(h.lo, h.hi);
      model(h);
      cmp_seg(exp_seg(old, 1'h1));
      check_out(h);
      ctl_inst.set_alt(1'h0);
      cmp_seg(exp_seg(old, 1'h0));
      @(posedge clk) srst <= 1'h1;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      repeat (8) @(posedge clk);
      cmp_seg(exp_seg(old, 1'h0));
      check_out(h);
      ctl_inst.latch();
      cmp_seg(exp_seg(e, 1'h0));
      report_and_stop();
   end
   initial begin
      #300000;
      n_fail++;
      report_and_stop();
   end
endmodule
